// ==== verilog/autorange_ratio_control.v ====
// Range and ratio control with AXI4-Lite registers.
// Assumes front-end detector levels and pulses are synchronous to clk_sys.
`include "autorange_defs.vh"
`default_nettype none
module autorange_ratio_control (
    input wire clk_sys,
    input wire rst_n,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire sample_gate,
    input wire count_pulse,
    input wire input_negative,
    input wire external_reference_input_negative,
    input wire external_reference_input_above_lim,
    input wire auto_step_pulse,
    output reg [1:0] range_ff,
    output reg [3:0] range_sel_ff,
    output reg pos_ref_sel_ff,
    output reg neg_ref_sel_ff,
    output reg reversal_relay_ff,
    output reg ref_gain_div10_ff,
    output reg display_negative_ff,
    output reg [23:0] bcd_out_ff,
    output reg reading_valid_ff
);
    // Control register fields
    reg [31:0] ctrl_ff;
    wire auto_en;
    wire ratio_mode;
    wire [1:0] manual_range;

    assign auto_en = ctrl_ff[`CTRL_AUTO];
    assign ratio_mode = ctrl_ff[`CTRL_RATIO];
    assign manual_range = ctrl_ff[`CTRL_MRANGE_LO +: 2];

    // Write channel capture
    reg aw_got_ff;
    reg w_got_ff;
    reg [7:0] waddr_ff;
    reg [31:0] wdata_ff;
    reg [3:0] wstrb_ff;
    wire aw_take;
    wire w_take;
    wire [7:0] wr_addr;
    wire [31:0] wr_data;
    wire [3:0] wr_strb;
    wire wr_fire;

    assign s_axi_awready = ~aw_got_ff & ~s_axi_bvalid;
    assign s_axi_wready = ~w_got_ff & ~s_axi_bvalid;
    assign aw_take = s_axi_awvalid & s_axi_awready;
    assign w_take = s_axi_wvalid & s_axi_wready;
    assign wr_addr = aw_got_ff ? waddr_ff : s_axi_awaddr;
    assign wr_data = w_got_ff ? wdata_ff : s_axi_wdata;
    assign wr_strb = w_got_ff ? wstrb_ff : s_axi_wstrb;
    assign wr_fire = (aw_got_ff | aw_take) & (w_got_ff | w_take);

    // Read channel
    assign s_axi_arready = ~s_axi_rvalid;

    // Measurement path
    wire [17:0] count_now;
    wire [23:0] bcd_now;
    wire sample_done;
    reg sign_latch_ff;
    reg [17:0] reading_ff;
    reg overrange_ff;

    count_accum u_accum (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .gate(sample_gate),
        .pulse(count_pulse),
        .count_ff(count_now),
        .bcd_ff(bcd_now),
        .done_ff(sample_done)
    );

    // Range command detectors on the finished count
    wire [17:0] up_lim;
    wire [17:0] dn_lim;
    wire up_cmd;
    wire dn_cmd;
    wire [1:0] floor_range;

    assign up_lim = ratio_mode ? `RATIO_UP_LIM : `VOLT_UP_LIM;
    assign dn_lim = ratio_mode ? `RATIO_DN_LIM : `VOLT_DN_LIM;
    assign up_cmd = count_now > up_lim;
    assign dn_cmd = count_now < dn_lim;
    // Ratio autoranging never uses the 2 V range
    assign floor_range = ratio_mode ? `RANGE_20V : `RANGE_2V;

    // Pending step: one per finished sample, spent on the step clock
    reg up_pend_ff;
    reg dn_pend_ff;
    reg nxt_up_pend;
    reg nxt_dn_pend;
    reg [1:0] nxt_range;

    always @* begin
        nxt_up_pend = up_pend_ff;
        nxt_dn_pend = dn_pend_ff;
        nxt_range = range_ff;
        if (!auto_en) begin
            nxt_up_pend = 1'b0;
            nxt_dn_pend = 1'b0;
            nxt_range = manual_range;
        end else begin
            if (auto_step_pulse) begin
                if (range_ff < floor_range) begin
                    nxt_range = floor_range;
                end else if (up_pend_ff && range_ff != `RANGE_1000V) begin
                    nxt_range = range_ff + 2'h1;
                end else if (dn_pend_ff && range_ff > floor_range) begin
                    nxt_range = range_ff - 2'h1;
                end
                nxt_up_pend = 1'b0;
                nxt_dn_pend = 1'b0;
            end
            // New command wins over the clear by the step clock
            if (sample_done) begin
                nxt_up_pend = up_cmd;
                nxt_dn_pend = dn_cmd & ~up_cmd;
            end
        end
    end

    // Range state
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            range_ff <= `RANGE_2V;
            range_sel_ff <= 4'h1;
            up_pend_ff <= 1'b0;
            dn_pend_ff <= 1'b0;
        end else begin
            range_ff <= nxt_range;
            range_sel_ff <= 4'h1 << nxt_range;
            up_pend_ff <= nxt_up_pend;
            dn_pend_ff <= nxt_dn_pend;
        end
    end

    // Ratio sign is the quotient's sign; the gate freezes it at its end
    reg nxt_sign;

    always @* begin
        nxt_sign = sign_latch_ff;
        if (sample_gate) begin
            if (ratio_mode) begin
                nxt_sign = input_negative ^ external_reference_input_negative;
            end else begin
                nxt_sign = input_negative;
            end
        end
    end

    // Reference selection and sign
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            pos_ref_sel_ff <= 1'b1;
            neg_ref_sel_ff <= 1'b0;
            reversal_relay_ff <= 1'b0;
            ref_gain_div10_ff <= 1'b0;
            sign_latch_ff <= 1'b0;
            display_negative_ff <= 1'b0;
        end else begin
            pos_ref_sel_ff <= ~input_negative;
            neg_ref_sel_ff <= input_negative;
            reversal_relay_ff <= external_reference_input_negative;
            ref_gain_div10_ff <= external_reference_input_above_lim;
            // Sign held from the end of the gate, not mid-sample
            sign_latch_ff <= nxt_sign;
            if (sample_done) begin
                display_negative_ff <= sign_latch_ff;
            end
        end
    end

    // Reading outputs
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            reading_ff <= 18'h0_0000;
            bcd_out_ff <= 24'h00_0000;
            reading_valid_ff <= 1'b0;
            overrange_ff <= 1'b0;
        end else begin
            reading_valid_ff <= sample_done;
            if (sample_done) begin
                reading_ff <= count_now;
                bcd_out_ff <= bcd_now;
                overrange_ff <= count_now > `FULL_SCALE;
            end
        end
    end

    // Write decode; the read-only words accept and drop writes
    reg wr_is_ctrl;
    reg wr_is_ro;
    wire [7:0] wr_word;

    assign wr_word = {wr_addr[7:2], 2'h0};

    always @* begin
        wr_is_ctrl = 1'b0;
        wr_is_ro = 1'b0;
        if (wr_word == `REG_CTRL) begin
            wr_is_ctrl = 1'b1;
        end else if (wr_word == `REG_STATUS) begin
            wr_is_ro = 1'b1;
        end else if (wr_word == `REG_READING) begin
            wr_is_ro = 1'b1;
        end else if (wr_word == `REG_BCD) begin
            wr_is_ro = 1'b1;
        end
    end

    // Write side
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            waddr_ff <= 8'h00;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            ctrl_ff <= `CTRL_RESET;
        end else begin
            if (aw_take) begin
                waddr_ff <= s_axi_awaddr;
            end
            if (w_take) begin
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_got_ff <= 1'b0;
                w_got_ff <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (wr_is_ctrl) begin
                    s_axi_bresp <= `RESP_OKAY;
                    // Only the low byte holds writable fields
                    if (wr_strb[0]) begin
                        ctrl_ff <= {26'h000_0000, wr_data[5:4], 2'h0,
                                    wr_data[1:0]};
                    end
                end else if (wr_is_ro) begin
                    s_axi_bresp <= `RESP_OKAY;
                end else begin
                    s_axi_bresp <= `RESP_SLVERR;
                end
            end else begin
                if (aw_take) begin
                    aw_got_ff <= 1'b1;
                end
                if (w_take) begin
                    w_got_ff <= 1'b1;
                end
                if (s_axi_bvalid && s_axi_bready) begin
                    s_axi_bvalid <= 1'b0;
                end
            end
        end
    end

    // Read side
    wire [31:0] status_word;

    assign status_word = {19'h0_0000, overrange_ff, display_negative_ff,
                          ref_gain_div10_ff, reversal_relay_ff,
                          neg_ref_sel_ff, up_pend_ff, dn_pend_ff,
                          range_sel_ff, range_ff};

    reg [31:0] nxt_rdata;
    reg [1:0] nxt_rresp;
    wire [7:0] rd_word;

    assign rd_word = {s_axi_araddr[7:2], 2'h0};

    // Unmapped words read as zero with an error response
    always @* begin
        nxt_rdata = 32'h0000_0000;
        nxt_rresp = `RESP_OKAY;
        if (rd_word == `REG_CTRL) begin
            nxt_rdata = ctrl_ff;
        end else if (rd_word == `REG_STATUS) begin
            nxt_rdata = status_word;
        end else if (rd_word == `REG_READING) begin
            nxt_rdata = {14'h0000, reading_ff};
        end else if (rd_word == `REG_BCD) begin
            nxt_rdata = {8'h00, bcd_out_ff};
        end else begin
            nxt_rresp = `RESP_SLVERR;
        end
    end

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= nxt_rresp;
            s_axi_rdata <= nxt_rdata;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== verilog/autorange_defs.vh ====
// Constants for the autorange and ratio control block.
// Assumes one 100 MHz clock and an AXI4-Lite master with 32-bit data.
// Behaviour
// - Ratio mode sign is positive when input and reference polarities agree.
// - Negative external reference drives the reversal relay on.
// - Reference gain is unity up to 10.5 V, 0.1 from 10.5 to 100 V.
// - Ratio mode: up-range above 180,000 counts, down-range below 14,000.
// - Range commands load an up/down counter stepped by auto-range clock pulses.
// - Input polarity picks the +10 V or -10 V reference and the sign.
// - Samples are counts of 12 MHz pulses; full scale is 199,000.
// - Counts are accumulated and shown as 5 1/2 digits and as BCD.
// - Automatic ranging only in auto mode, driven only by detector commands; in ratio mode a step also lifts the 2 V range to 20 V.
// - With no input in auto mode the range settles at 2 V; in ratio mode it settles at 20 V.
// - Voltage mode: reading above 195,000 counts steps one range up.
// - Voltage mode: reading below 12,000 counts steps one range down.
// - Ratio auto ranging uses only the 20 V, 200 V and 1000 V ranges.
// - Range is one of four: 2, 20, 200, 1000 V full scale.
// - Up-range on the 1000 V range has no effect.
`ifndef AUTORANGE_DEFS_VH
`define AUTORANGE_DEFS_VH

`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_READING 8'h08
`define REG_BCD 8'h0C

`define CTRL_AUTO 0
`define CTRL_RATIO 1
`define CTRL_MRANGE_LO 4
`define CTRL_RESET 32'h0000_0000

`define RANGE_2V 2'h0
`define RANGE_20V 2'h1
`define RANGE_200V 2'h2
`define RANGE_1000V 2'h3

`define FULL_SCALE 18'h3_0958
`define VOLT_UP_LIM 18'h2_F9B8
`define VOLT_DN_LIM 18'h0_2EE0
`define RATIO_UP_LIM 18'h2_BF20
`define RATIO_DN_LIM 18'h0_36B0

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== verilog/count_accum.v ====
// Pulse accumulator: binary and BCD counts of converter pulses.
// Assumes gate and pulse are synchronous to clk_sys.
`default_nettype none
module count_accum (
    input wire clk_sys,
    input wire rst_n,
    input wire gate,
    input wire pulse,
    output reg [17:0] count_ff,
    output reg [23:0] bcd_ff,
    output reg done_ff
);
    reg gate_ff;
    reg [17:0] bin_ff;
    wire start;
    wire stop;
    wire [6:0] carry;
    wire [23:0] bcd_now;
    genvar g;

    assign start = gate & ~gate_ff;
    assign stop = ~gate & gate_ff;
    assign carry[0] = pulse & gate & ~start;

    // One BCD digit per stage, ripple carry on nine
    generate
        for (g = 0; g < 6; g = g + 1) begin : dig
            reg [3:0] dig_ff;
            wire at9;
            assign at9 = (dig_ff == 4'h9);
            assign carry[g + 1] = carry[g] & at9;
            assign bcd_now[g * 4 +: 4] = dig_ff;
            always @(posedge clk_sys) begin
                if (!rst_n || start) begin
                    dig_ff <= 4'h0;
                end else if (carry[g]) begin
                    dig_ff <= at9 ? 4'h0 : dig_ff + 4'h1;
                end
            end
        end
    endgenerate

    // Binary count saturates so an overload never wraps to a small reading; the BCD digits wrap past 999999
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            gate_ff <= 1'b0;
            bin_ff <= 18'h0_0000;
            count_ff <= 18'h0_0000;
            bcd_ff <= 24'h00_0000;
            done_ff <= 1'b0;
        end else begin
            gate_ff <= gate;
            done_ff <= stop;
            if (start) begin
                bin_ff <= 18'h0_0000;
            end else if (carry[0] && bin_ff != 18'h3_FFFF) begin
                bin_ff <= bin_ff + 18'h0_0001;
            end
            if (stop) begin
                count_ff <= bin_ff;
                bcd_ff <= bcd_now;
            end
        end
    end
endmodule
`default_nettype wire

// ==== tb/autorange_props.sv ====
// Concurrent checks on the range and reference outputs.
// Assumes binding to the range control top; sees only its ports.
`default_nettype none
module autorange_props (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic s_axi_wvalid,
    input wire logic sample_gate,
    input wire logic input_negative,
    input wire logic external_reference_input_negative,
    input wire logic external_reference_input_above_lim,
    input wire logic auto_step_pulse,
    input wire logic [1:0] range_ff,
    input wire logic [3:0] range_sel_ff,
    input wire logic pos_ref_sel_ff,
    input wire logic neg_ref_sel_ff,
    input wire logic reversal_relay_ff,
    input wire logic ref_gain_div10_ff,
    input wire logic reading_valid_ff
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // Past terms gated by past reset: inputs may move while reset holds
    ref_select_a: assert property (
        $past(rst_n) |-> neg_ref_sel_ff == $past(input_negative) && pos_ref_sel_ff != neg_ref_sel_ff)
        else $error("reference select wrong");
    relay_follow_a: assert property (
        $past(rst_n) |-> reversal_relay_ff == $past(external_reference_input_negative))
        else $error("reversal relay wrong");
    gain_follow_a: assert property (
        $past(rst_n) |-> ref_gain_div10_ff == $past(external_reference_input_above_lim))
        else $error("reference gain wrong");
    range_onehot_a: assert property (range_sel_ff == (4'h1 << range_ff))
        else $error("range select not one-hot of range");
    step_one_a: assert property (
        $past(rst_n) && $past(auto_step_pulse) && $changed(range_ff)
        |-> range_ff == $past(range_ff) + 2'h1 || range_ff == $past(range_ff) - 2'h1)
        else $error("range moved more than one step");
    range_hold_a: assert property (
        $past(rst_n) && !$past(auto_step_pulse) && !$past(s_axi_wvalid) && !$past(s_axi_wvalid, 2)
        |-> $stable(range_ff))
        else $error("range moved without a cause");
    no_wrap_a: assert property (
        $past(rst_n) && $past(auto_step_pulse)
        |-> !($past(range_ff) == 2'h3 && range_ff == 2'h0) && !($past(range_ff) == 2'h0 && range_ff == 2'h3))
        else $error("range wrapped past an end");
    reading_pulse_a: assert property (reading_valid_ff |=> !reading_valid_ff)
        else $error("reading strobe too long");
    reading_after_gate_a: assert property (
        reading_valid_ff |-> !$past(sample_gate, 2) && $past(sample_gate, 3))
        else $error("reading not two cycles after gate end");
endmodule
bind autorange_ratio_control autorange_props props_u (
    .clk_sys, .rst_n, .s_axi_wvalid, .sample_gate, .input_negative, .external_reference_input_negative,
    .external_reference_input_above_lim, .auto_step_pulse, .range_ff, .range_sel_ff, .pos_ref_sel_ff,
    .neg_ref_sel_ff, .reversal_relay_ff, .ref_gain_div10_ff, .reading_valid_ff
);
`default_nettype wire

// ==== tb/front_end_model.sv ====
// Converter front end: sample gate and pulse train.
// Assumes start is a one-cycle request made while idle.
`default_nettype none
module front_end_model (
    input wire logic clk_sys,
    input wire logic start,
    input wire logic [17:0] n_pulses,
    input wire logic slow,
    output logic sample_gate,
    output logic count_pulse,
    output logic busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [17:0] left_ff = 18'h0_0000;
    logic phase_ff = 1'h0;
    initial begin
        sample_gate = 1'h0;
        count_pulse = 1'h0;
        busy = 1'h0;
    end
    // Slow mode puts a pulse on every second cycle; fast pulses every cycle to keep runs short
    always @(posedge clk_sys) begin
        count_pulse <= 1'h0;
        if (start && !busy) begin
            busy <= 1'h1;
            sample_gate <= 1'h1;
            left_ff <= n_pulses;
            phase_ff <= 1'h0;
        end else if (busy) begin
            phase_ff <= !phase_ff;
            if (left_ff == 18'h0_0000) begin
                sample_gate <= 1'h0;
                busy <= 1'h0;
            end else if (!slow || phase_ff) begin
                count_pulse <= 1'h1;
                left_ff <= left_ff - 18'h0_0001;
            end
        end
    end
endmodule
`default_nettype wire

// ==== tb/test_autorange_ratio_control.sv ====
// Self-checking bench for the range and ratio control block.
// Assumes the front end model drives the gate and pulse train.
`default_nettype none
module test_autorange_ratio_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'h0, rst_n = 1'h0, start = 1'h0, slow = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, auto_step_pulse = 1'h0;
    logic input_negative = 1'h0, external_reference_input_negative = 1'h0, external_reference_input_above_lim = 1'h0;
    logic [17:0] n_pulses = 18'h0_0000;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, range_ff;
    logic [31:0] s_axi_rdata;
    logic [3:0] range_sel_ff;
    logic [23:0] bcd_out_ff;
    logic sample_gate, count_pulse, busy, pos_ref_sel_ff, neg_ref_sel_ff;
    logic reversal_relay_ff, ref_gain_div10_ff, display_negative_ff, reading_valid_ff;
    int n_errors = 0;
    int n_tests = 0;
    always #5 clk_sys = ~clk_sys;
    autorange_ratio_control dut_u (.*);
    front_end_model fe_u (.*);
    task automatic tally_and_finish();
        if (n_errors == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic timeout_hit();
        n_errors++;
        tally_and_finish();
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Ready and valid are read right after the edge, before that edge's updates land
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
        int i;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk_sys);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid === 1'h1) break;
        end
        if (i == 50) timeout_hit();
        check(s_axi_bresp, resp, "bresp");
        s_axi_bready <= 1'h0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] resp);
        int i;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk_sys);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid === 1'h1) break;
        end
        if (i == 50) timeout_hit();
        check(s_axi_rdata, exp, "rdata");
        check(s_axi_rresp, resp, "rresp");
        s_axi_rready <= 1'h0;
        @(posedge clk_sys);
    endtask
    task automatic sample(input logic [17:0] n);
        int i;
        n_pulses <= n;
        start <= 1'h1;
        @(posedge clk_sys);
        start <= 1'h0;
        for (i = 0; i < 2 * n + 40 && reading_valid_ff !== 1'h1; i++) @(posedge clk_sys);
        if (reading_valid_ff !== 1'h1) timeout_hit();
    endtask
    task automatic step();
        auto_step_pulse <= 1'h1;
        @(posedge clk_sys);
        auto_step_pulse <= 1'h0;
        repeat (2) @(posedge clk_sys);
    endtask
    initial begin
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'h1;
        @(posedge clk_sys);
        check(range_sel_ff, 4'h1, "range_sel");
        rd(8'h00, 32'h0000_0000, 2'h0);
        rd(8'h04, 32'h0000_0004, 2'h0);
        rd(8'h10, 32'h0000_0000, 2'h2);
        wr(8'h10, 32'h0000_0031, 2'h2);
        external_reference_input_negative <= 1'h1;
        external_reference_input_above_lim <= 1'h1;
        input_negative <= 1'h1;
        repeat (2) @(posedge clk_sys);
        rd(8'h04, 32'h0000_0704, 2'h0);
        external_reference_input_negative <= 1'h0;
        external_reference_input_above_lim <= 1'h0;
        wr(8'h00, 32'h0000_0030, 2'h0);
        step();
        rd(8'h04, 32'h0000_0123, 2'h0);
        wr(8'h00, 32'h0000_0031, 2'h0);
        sample(18'h0_2EDF);
        check(bcd_out_ff, 24'h01_1999, "bcd_out");
        check(display_negative_ff, 1'h1, "sign");
        rd(8'h08, 32'h0000_2EDF, 2'h0);
        rd(8'h04, 32'h0000_0963, 2'h0);
        step();
        input_negative <= 1'h0;
        slow <= 1'h1;
        sample(18'h0_2EE0);
        step();
        rd(8'h04, 32'h0000_0012, 2'h0);
        slow <= 1'h0;
        for (int k = 0; k < 3; k++) begin
            sample(18'h0_0000);
            step();
        end
        rd(8'h04, 32'h0000_0004, 2'h0);
        wr(8'h00, 32'h0000_0003, 2'h0);
        step();
        input_negative <= 1'h1;
        external_reference_input_negative <= 1'h1;
        sample(18'h0_36AF);
        rd(8'h04, 32'h0000_0349, 2'h0);
        step();
        input_negative <= 1'h0;
        sample(18'h0_36B0);
        rd(8'h04, 32'h0000_0A09, 2'h0);
        rd(8'h0C, 32'h0001_4000, 2'h0);
        wr(8'h08, 32'h0000_0000, 2'h0);
        rd(8'h08, 32'h0000_36B0, 2'h0);
        s_axi_wstrb <= 4'hE;
        wr(8'h00, 32'h0000_0000, 2'h0);
        rd(8'h00, 32'h0000_0003, 2'h0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
